// file: verilog/ata_read_device.sv
// device end: task-file registers and read-command executor with its sector buffer
// assumes the host end on the same clock; media content is generated from the address
// Function
// - geometry opcode uses only count and head fields
// - buffer read returns buffer as is
// - host arms DMA before DMA read opcode
// - each DMA word qualified by request and acknowledge
// - DMA read gives one interrupt at end
// - BSY or DRQ held through DMA phase
// - block read qualifies DRQ once per block
// - block read interrupts only at block start
// - remainder sectors form one final partial block
// - abort block read when unprogrammed or disabled
// - post block error, still transfer block
// - continue after error only when correctable
// - count 1..256, zero means 256
// - per sector: busy, load, DRQ, interrupt
// - success leaves last sector address
// - error stops at failing sector, data kept
// - long read returns 516 bytes, one sector
// - 256 words then four filler bytes
// - LBA bits split over head, cylinders, sector
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ata_rd_params.svh"
module ata_read_device #(
  parameter logic [7:0] SPT_RST = 8'h3F
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [7:0] BLOCK_COUNT,
  input wire logic MULTIPLE_EN,
  input wire logic ERR_INJECT,
  input wire logic [27:0] ERR_ADDR,
  input wire logic ERR_CORRECTABLE,
  ata_link_if.device link
);
  import ata_rd_pkg::*;

  dev_reg_t r, n;
  logic [27:0] cur, stepped, diff;
  logic [8:0] bsz, blk, last_idx;
  logic [15:0] word;
  logic take, hit_here, last_sec;

  // ----------------------------------------
  // address stepping and generated media data
  // ----------------------------------------
  // 28-bit address over head, cylinders, sector
  assign cur = {r.head[3:0], r.cyl_hi, r.cyl_lo, r.sector};
  assign hit_here = ERR_INJECT && (cur == ERR_ADDR);
  assign diff = ERR_ADDR - cur;

  always_comb begin
    stepped = cur;
    if (r.head[`HEAD_LBA_BIT]) begin
      stepped = cur + 28'h1;
    end else if (r.sector >= r.spt) begin
      stepped[7:0] = 8'h01;
      if (r.head[3:0] >= r.max_head) begin
        stepped[27:24] = 4'h0;
        stepped[23:8] = cur[23:8] + 16'h1;
      end else begin
        stepped[27:24] = cur[27:24] + 4'h1;
      end
    end else begin
      stepped[7:0] = r.sector + 8'h01;
    end
  end

  // block size, the partial block falls out of min(left, bsz)
  always_comb begin
    unique case (r.mode)
      M_MULT: bsz = {1'b0, BLOCK_COUNT};
      M_DMA: bsz = r.left;
      default: bsz = 9'd1;
    endcase
    blk = (r.left < bsz) ? r.left : bsz;
    last_idx = (r.mode == M_LONG) ? `LONG_LAST_IDX : (`SECTOR_WORDS - 9'd1);
  end

  // word data first, then filler bytes in the low lane
  always_comb begin
    if (r.mode == M_BUF) begin
      word = r.buffer[r.widx[7:0]];
    end else if (r.widx >= `SECTOR_WORDS) begin
      word = {8'h00, cur[7:0] ^ r.widx[7:0] ^ `FILLER_SEED};
    end else begin
      word = {cur[7:0] ^ r.widx[7:0], r.widx[7:0]};
      if (hit_here && r.mode != M_LONG) begin
        word = ~word;
      end
    end
  end

  // DMA words only move with acknowledge
  assign take = link.reg_rd && r.st == S_XFER &&
                ((r.mode == M_DMA) ? link.dmack : (link.reg_addr == `TF_DATA && !link.dmack));
  assign last_sec = (r.left == 9'd1) || (r.stop && r.blk_left == 9'd1);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = r;
    // status read clears the interrupt; any event below overrides it
    if (link.reg_rd && !link.dmack) begin
      unique case (link.reg_addr)
        `TF_DATA: n.rd_data = 16'h0000;
        `TF_FEATURE: n.rd_data = {8'h00, r.err};
        `TF_COUNT: n.rd_data = {8'h00, r.count};
        `TF_SECTOR: n.rd_data = {8'h00, r.sector};
        `TF_CYL_LO: n.rd_data = {8'h00, r.cyl_lo};
        `TF_CYL_HI: n.rd_data = {8'h00, r.cyl_hi};
        `TF_HEAD: n.rd_data = {8'h00, r.head};
        `TF_OPCODE: begin
          n.rd_data = {8'h00, r.bsy, !r.bsy, 2'b01, r.drq, r.corr, 1'b0, r.errb};
          n.intrq = 1'b0;
        end
      endcase
    end
    unique case (r.st)
      S_IDLE: begin
        if (link.reg_wr) begin
          unique case (link.reg_addr)
            `TF_FEATURE: n.feature = link.wr_data;
            `TF_COUNT: n.count = link.wr_data;
            `TF_SECTOR: n.sector = link.wr_data;
            `TF_CYL_LO: n.cyl_lo = link.wr_data;
            `TF_CYL_HI: n.cyl_hi = link.wr_data;
            `TF_HEAD: n.head = link.wr_data;
            `TF_OPCODE: begin
              n.err = 8'h00;
              n.errb = 1'b0;
              n.corr = 1'b0;
              n.stop = 1'b0;
              n.hold = 1'b0;
              n.dly = 8'h00;
              n.left = (r.count == 8'h00) ? 9'd256 : {1'b0, r.count};
              // fields not named per opcode are never read
              unique case (link.wr_data)
                `OP_INIT_GEOM: begin
                  n.spt = r.count;
                  n.max_head = r.head[3:0];
                  n.intrq = 1'b1;
                end
                `OP_READ_BUF: begin
                  // no load, buffer goes out untouched
                  n.mode = M_BUF;
                  n.left = 9'd1;
                  n.blk_left = 9'd1;
                  n.widx = 9'd0;
                  n.drq = 1'b1;
                  n.intrq = 1'b1;
                  n.st = S_XFER;
                end
                `OP_SECT_A, `OP_SECT_B, `OP_DMA_A, `OP_DMA_B, `OP_LONG_A, `OP_LONG_B: begin
                  n.mode = (link.wr_data[7:4] == 4'hC) ? M_DMA :
                           (link.wr_data[1] ? M_LONG : M_SECT);
                  // long read is a single sector
                  if (link.wr_data[1] && link.wr_data[7:4] != 4'hC) begin
                    n.left = 9'd1;
                  end
                  n.bsy = 1'b1;
                  n.st = S_LOAD;
                end
                `OP_MULT: begin
                  // abort when no block count or disabled
                  if (BLOCK_COUNT == 8'h00 || !MULTIPLE_EN) begin
                    n.err = `ERR_ABORT;
                    n.errb = 1'b1;
                    n.intrq = 1'b1;
                  end else begin
                    n.mode = M_MULT;
                    n.bsy = 1'b1;
                    n.st = S_LOAD;
                  end
                end
                default: begin
                  n.err = `ERR_ABORT;
                  n.errb = 1'b1;
                  n.intrq = 1'b1;
                end
              endcase
            end
            default: n.feature = r.feature;
          endcase
        end
      end
      S_LOAD: begin
        n.dly = r.dly + 8'h01;
        if (r.dly >= 8'(`LOAD_CYCLES - 1)) begin
          n.st = S_XFER;
          n.bsy = 1'b0;
          n.widx = 9'd0;
          n.blk_left = blk;
          // DRQ raised once at each block start
          n.drq = 1'b1;
          if (r.mode == M_DMA) begin
            n.dmarq = 1'b1;
          end else begin
            // interrupt with DRQ at block start
            n.intrq = 1'b1;
          end
          // error posted here, block still sent
          // long read skips the ECC check
          if (ERR_INJECT && r.mode != M_LONG && diff < {19'h0, blk}) begin
            if (ERR_CORRECTABLE) begin
              n.corr = 1'b1;
            end else begin
              n.errb = 1'b1;
              n.err = `ERR_UNC;
              n.stop = 1'b1;
            end
          end
        end
      end
      S_XFER: begin
        if (take) begin
          n.rd_data = word;
          if (r.mode != M_BUF && r.widx < `SECTOR_WORDS) begin
            n.buffer[r.widx[7:0]] = word;
          end
          n.widx = r.widx + 9'd1;
          if (r.widx == last_idx) begin
            if (last_sec) begin
              // address stays on the last sector read
              n.st = S_IDLE;
              n.drq = 1'b0;
              n.dmarq = 1'b0;
              if (r.mode == M_DMA) begin
                n.intrq = 1'b1;
              end
            end else begin
              n.left = r.left - 9'd1;
              n.blk_left = r.blk_left - 9'd1;
              n.widx = 9'd0;
              // address freezes on the failing sector
              if (hit_here && r.stop) begin
                n.hold = 1'b1;
              end else if (!r.hold) begin
                {n.head[3:0], n.cyl_hi, n.cyl_lo, n.sector} = stepped;
              end
              // between blocks DRQ drops as BSY rises
              if (r.blk_left == 9'd1) begin
                n.st = S_LOAD;
                n.dly = 8'h00;
                n.bsy = 1'b1;
                n.drq = 1'b0;
              end
            end
          end
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.count <= `TF_COUNT_RST;
      r.sector <= `TF_SECTOR_RST;
      r.spt <= SPT_RST;
    end else if (CE) begin
      r <= n;
    end
  end

  assign link.rd_data = r.rd_data;
  assign link.intrq = r.intrq;
  assign link.dmarq = r.dmarq;
endmodule

// file: verilog/ata_rd_params.svh
// register offsets, opcodes, field positions, reset values and timing counts
// assumes a single 100 MHz clock shared by both ends of the task-file link
`ifndef ATA_RD_PARAMS_SVH
`define ATA_RD_PARAMS_SVH
// ----------------------------------------
// task-file offsets on the link
// ----------------------------------------
`define TF_DATA 3'h0
`define TF_FEATURE 3'h1
`define TF_COUNT 3'h2
`define TF_SECTOR 3'h3
`define TF_CYL_LO 3'h4
`define TF_CYL_HI 3'h5
`define TF_HEAD 3'h6
`define TF_OPCODE 3'h7
`define TF_COUNT_RST 8'h01
`define TF_SECTOR_RST 8'h01
`define HEAD_LBA_BIT 6
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_INIT_GEOM 8'h91
`define OP_READ_BUF 8'hE4
`define OP_DMA_A 8'hC8
`define OP_DMA_B 8'hC9
`define OP_MULT 8'hC4
`define OP_LONG_A 8'h22
`define OP_LONG_B 8'h23
`define OP_SECT_A 8'h20
`define OP_SECT_B 8'h21
// ----------------------------------------
// status and error fields
// ----------------------------------------
`define ERR_ABORT 8'h04
`define ERR_UNC 8'h40
`define SECTOR_WORDS 9'd256
`define LONG_LAST_IDX 9'd259
`define FILLER_SEED 8'hA5
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define LOAD_TIME_NS 100
`define LOAD_CYCLES ((`LOAD_TIME_NS * `CLK_MHZ + 999) / 1000)
// ----------------------------------------
// controller registers on the AHB-Lite side
// ----------------------------------------
`define HR_CTRL 8'h00
`define HR_ADDR 8'h04
`define HR_WDATA 8'h08
`define HR_RDATA 8'h0C
`define HR_STAT 8'h10
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_DMACK 2
`define CTRL_DMA_ARM 3
`endif

// file: verilog/ata_rd_pkg.sv
// types shared by the task-file device and its host controller
// assumes the constants of ata_rd_params.svh
package ata_rd_pkg;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_LOAD = 2'b01, S_XFER = 2'b10} dev_state_t;
  typedef enum logic [2:0] {
    M_SECT = 3'b000, M_MULT = 3'b001, M_DMA = 3'b010, M_LONG = 3'b011, M_BUF = 3'b100
  } read_mode_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_ISSUE = 2'b01, H_CAPTURE = 2'b10} host_state_t;

  typedef struct packed {
    dev_state_t st;
    read_mode_t mode;
    logic [7:0] feature, count, sector, cyl_lo, cyl_hi, head, err;
    logic bsy, drq, corr, errb, intrq, dmarq, stop, hold;
    logic [15:0] rd_data;
    logic [8:0] left, blk_left, widx;
    logic [7:0] spt;
    logic [3:0] max_head;
    logic [7:0] dly;
    logic [255:0][15:0] buffer;
  } dev_reg_t;

  typedef struct packed {
    host_state_t st;
    logic [31:0] hrdata;
    logic hreadyout, dp_wr;
    logic [7:0] dp_addr;
    logic reg_wr, reg_rd, dmack;
    logic [2:0] reg_addr;
    logic [7:0] wr_data;
    logic [15:0] result;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic write, use_dmack, dma_arm, refused;
  } host_reg_t;
endpackage

// file: verilog/ata_link_if.sv
// task-file link between host controller and read-command device
// assumes both ends run on the same clock; every signal is driven from a flop
`timescale 1ns/1ps
interface ata_link_if;
  logic reg_wr;
  logic reg_rd;
  logic dmack;
  logic [2:0] reg_addr;
  logic [7:0] wr_data;
  logic [15:0] rd_data;
  logic intrq;
  logic dmarq;
  modport device(input reg_wr, input reg_rd, input dmack, input reg_addr, input wr_data,
                 output rd_data, output intrq, output dmarq);
  modport host(output reg_wr, output reg_rd, output dmack, output reg_addr, output wr_data,
               input rd_data, input intrq, input dmarq);
endinterface

// file: verilog/ata_read_host.sv
// host end: AHB-Lite slave registers that drive single task-file link accesses
// assumes one AHB master, zero-wait answers, and the device on the same clock
`timescale 1ns/1ps
`include "ata_rd_params.svh"
module ata_read_host (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [7:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  ata_link_if.host link
);
  import ata_rd_pkg::*;

  host_reg_t r, n;
  logic [31:0] rd_mux;
  logic go;

  // ----------------------------------------
  // register read view
  // ----------------------------------------
  always_comb begin
    unique case (HADDR)
      `HR_CTRL: rd_mux = {28'h0, r.dma_arm, r.use_dmack, r.write, 1'b0};
      `HR_ADDR: rd_mux = {29'h0, r.addr};
      `HR_WDATA: rd_mux = {24'h0, r.wdata};
      `HR_RDATA: rd_mux = {16'h0, r.result};
      `HR_STAT: rd_mux = {28'h0, r.refused, link.dmarq, link.intrq, r.st != H_IDLE};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n = r;
    go = 1'b0;
    n.reg_wr = 1'b0;
    n.reg_rd = 1'b0;
    n.dmack = 1'b0;
    n.dp_wr = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      n.dp_wr = HWRITE;
      n.dp_addr = HADDR;
      if (!HWRITE) begin
        n.hrdata = rd_mux;
      end
    end
    if (r.dp_wr) begin
      unique case (r.dp_addr)
        `HR_CTRL: begin
          n.write = HWDATA[`CTRL_WRITE];
          n.use_dmack = HWDATA[`CTRL_DMACK];
          n.dma_arm = HWDATA[`CTRL_DMA_ARM];
          go = HWDATA[`CTRL_GO];
          if (HWDATA[`CTRL_GO]) begin
            n.refused = 1'b0;
          end
        end
        `HR_ADDR: n.addr = HWDATA[2:0];
        `HR_WDATA: n.wdata = HWDATA[7:0];
        default: n.addr = r.addr;
      endcase
    end
    unique case (r.st)
      H_IDLE: begin
        if (go) begin
          // no DMA read opcode unless the channel is armed
          if (n.write && n.addr == `TF_OPCODE &&
              (n.wdata == `OP_DMA_A || n.wdata == `OP_DMA_B) && !n.dma_arm) begin
            n.refused = 1'b1;
          end else begin
            n.reg_addr = n.addr;
            n.wr_data = n.wdata;
            n.reg_wr = n.write;
            n.reg_rd = !n.write;
            // acknowledge one DMA word per access
            n.dmack = !n.write && n.use_dmack;
            n.st = H_ISSUE;
          end
        end
      end
      H_ISSUE: n.st = r.reg_rd ? H_CAPTURE : H_IDLE;
      H_CAPTURE: begin
        n.result = link.rd_data;
        n.st = H_IDLE;
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.hreadyout <= 1'b1;
    end else if (CE) begin
      r <= n;
    end
  end

  assign HRDATA = r.hrdata;
  assign HREADYOUT = r.hreadyout;
  assign HRESP = 1'b0;
  assign link.reg_wr = r.reg_wr;
  assign link.reg_rd = r.reg_rd;
  assign link.dmack = r.dmack;
  assign link.reg_addr = r.reg_addr;
  assign link.wr_data = r.wr_data;
endmodule

// file: bench/ata_link_checker.sv
// link checker: timing relations between the two ends of the task-file link
// assumes one clock; the bench instantiates it beside the link interface
`timescale 1ns/1ps
`include "ata_rd_params.svh"
module ata_link_checker (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic dmack,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic intrq,
  input wire logic dmarq
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  // opcode edge to interrupt or request: the whole load time plus the flop stage
  localparam int LOAD_LAT = `LOAD_CYCLES + 1;
  // ----------------------------------------
  // words acknowledged while the request stands
  // ----------------------------------------
  logic [16:0] words_reg;
  logic [16:0] words_next;
  always_comb begin
    words_next = words_reg;
    if (!dmarq) begin
      words_next = 17'h00000;
    end else if (reg_rd && dmack) begin
      words_next = words_reg + 17'h00001;
    end
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      words_reg <= 17'h00000;
    end else begin
      words_reg <= words_next;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_pio_op;
    reg_wr && reg_addr == 3'h7 && (wr_data inside {`OP_SECT_A, `OP_SECT_B, `OP_LONG_A, `OP_LONG_B,
      `OP_MULT, `OP_READ_BUF, `OP_INIT_GEOM});
  endsequence
  sequence s_dma_op;
    reg_wr && reg_addr == 3'h7 && (wr_data inside {`OP_DMA_A, `OP_DMA_B});
  endsequence
  sequence s_quiet;
    !reg_wr && !reg_rd;
  endsequence
  property p_pio_intr;
    s_pio_op |-> ##[1:LOAD_LAT] intrq;
  endproperty
  property p_dma_req;
    s_dma_op |-> ##LOAD_LAT dmarq;
  endproperty
  property p_ack;
    dmack |-> reg_rd && dmarq;
  endproperty
  property p_end_intr;
    $fell(dmarq) |-> ##[0:1] intrq;
  endproperty
  property p_no_mid_intr;
    $rose(intrq) |-> !dmarq;
  endproperty
  property p_whole_sectors;
    $fell(dmarq) |-> words_reg[7:0] == 8'h00 && words_reg != 17'h00000;
  endproperty
  property p_rd_hold;
    !reg_rd |=> $stable(rd_data);
  endproperty
  property p_pulse;
    (reg_wr || reg_rd) |=> s_quiet [*2];
  endproperty
  a_pio_intr: assert property (p_pio_intr) else $error("no interrupt after opcode");
  a_dma_req: assert property (p_dma_req) else $error("no dma request after opcode");
  a_ack: assert property (p_ack) else $error("acknowledge without request");
  a_end_intr: assert property (p_end_intr) else $error("no interrupt at dma end");
  a_no_mid_intr: assert property (p_no_mid_intr) else $error("interrupt during dma");
  a_whole_sectors: assert property (p_whole_sectors) else $error("dma ended mid sector");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_pulse: assert property (p_pulse) else $error("link strobe too long");
endmodule

// file: bench/testbench.sv
// bench: host and device joined by the link, driven over AHB-Lite
// assumes one 100 MHz clock and the controller map of ata_rd_params.svh
`timescale 1ns/1ps
`include "ata_rd_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic clk, rst_n, hsel, hwrite, hready, hresp, arm, men, einj, ecorr;
  logic [7:0] haddr, bc;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [27:0] eaddr, a;
  logic [2:0] cur_a;
  logic [15:0] r;
  logic [31:0] x;
  int mismatches, n_checks;
  int cyc = 0;
  integer seed;
  ata_link_if ata_link_if_inst();
  ata_read_host ata_read_host_inst (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .link(ata_link_if_inst));
  ata_read_device ata_read_device_inst (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .BLOCK_COUNT(bc),
    .MULTIPLE_EN(men), .ERR_INJECT(einj), .ERR_ADDR(eaddr), .ERR_CORRECTABLE(ecorr), .link(ata_link_if_inst));
  ata_link_checker ata_link_checker_inst (.REF_CLK(clk), .RST_N(rst_n), .reg_wr(ata_link_if_inst.reg_wr),
    .reg_rd(ata_link_if_inst.reg_rd), .dmack(ata_link_if_inst.dmack), .reg_addr(ata_link_if_inst.reg_addr),
    .wr_data(ata_link_if_inst.wr_data), .rd_data(ata_link_if_inst.rd_data), .intrq(ata_link_if_inst.intrq),
    .dmarq(ata_link_if_inst.dmarq));
  // ----------------------------------------
  // bus and link tasks
  // ----------------------------------------
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  // one link access; the offset is rewritten only when it changes, to save bus cycles
  task automatic lk(input logic w, dk, input logic [2:0] ad, input logic [7:0] d, output logic [15:0] q);
    logic [31:0] y;
    if (ad !== cur_a) ahb(1'b1, `HR_ADDR, {29'h0, ad}, y);
    cur_a = ad;
    if (w) ahb(1'b1, `HR_WDATA, {24'h0, d}, y);
    ahb(1'b1, `HR_CTRL, {28'h0, arm, dk, w, 1'b1}, y);
    y = 32'h1;
    for (int k = 0; k < 20 && y[0] !== 1'b0; k++) ahb(1'b0, `HR_STAT, 32'h0, y);
    ahb(1'b0, `HR_RDATA, 32'h0, y);
    q = y[15:0];
  endtask
  function automatic logic [15:0] ew(input logic [27:0] sa, input int i, input bit inv);
    logic [15:0] v;
    v = {sa[7:0] ^ i[7:0], i[7:0]};
    return inv ? ~v : v;
  endfunction
  function automatic logic [27:0] rnd_a();
    logic [27:0] v;
    v = 28'($random(seed));
    v[7] = 1'b0;
    return v;
  endfunction
  task automatic rd_sec(input logic [27:0] sa, input bit inv, dk, chk);
    for (int i = 0; i < 256; i++) begin
      lk(1'b0, dk, 3'h0, 8'h00, r);
      if (chk) `CHK(r, ew(sa, i, inv))
    end
  endtask
  task automatic st(input logic [27:0] sa, input logic [7:0] cnt);
    lk(1'b1, 1'b0, 3'h1, 8'($random(seed)), r);
    lk(1'b1, 1'b0, 3'h2, cnt, r);
    for (int k = 0; k < 3; k++) lk(1'b1, 1'b0, 3'(k + 3), 8'(sa >> (8 * k)), r);
    lk(1'b1, 1'b0, 3'h6, {4'hE, sa[27:24]}, r);
  endtask
  task automatic chk_a(input logic [27:0] sa);
    for (int k = 0; k < 3; k++) begin
      lk(1'b0, 1'b0, 3'(k + 3), 8'h00, r);
      `CHK(r[7:0], 8'(sa >> (8 * k)))
    end
    lk(1'b0, 1'b0, 3'h6, 8'h00, r);
    `CHK(r[3:0], sa[27:24])
  endtask
  task automatic stat(input logic [1:0] ei, input logic [7:0] es);
    ahb(1'b0, `HR_STAT, 32'h0, x);
    // a block load keeps the device busy; wait for its event before judging
    for (int k = 0; k < 20 && ei != 2'b00 && x[2:1] === 2'b00; k++) ahb(1'b0, `HR_STAT, 32'h0, x);
    `CHK(x[2:1], ei)
    lk(1'b0, 1'b0, 3'h7, 8'h00, r);
    `CHK(r[7:0], es)
  endtask
  task end_of_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    seed = 32'hD106;
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, einj, ecorr, eaddr} = '0;
    {arm, men, bc, cur_a} = {1'b1, 1'b1, 8'h00, 3'bxxx};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    lk(1'b0, 1'b0, 3'h2, 8'h00, r);
    `CHK(r[7:0], `TF_COUNT_RST)
    lk(1'b1, 1'b0, 3'h2, 8'h20, r);
    lk(1'b1, 1'b0, 3'h6, 8'hA3, r);
    lk(1'b1, 1'b0, 3'h7, `OP_INIT_GEOM, r);
    stat(2'b01, 8'h50);
    st(28'h3001220, 8'h02);
    lk(1'b1, 1'b0, 3'h6, 8'hA3, r);
    lk(1'b1, 1'b0, 3'h7, `OP_SECT_A, r);
    for (int s = 0; s < 2; s++) begin
      stat(2'b01, 8'h58);
      rd_sec(s ? 28'h0001301 : 28'h3001220, 1'b0, 1'b0, 1'b1);
    end
    stat(2'b00, 8'h50);
    chk_a(28'h0001301);
    for (int j = 0; j < 2; j++) begin
      a = rnd_a();
      st(a, 8'(j + 1));
      lk(1'b1, 1'b0, 3'h7, j ? `OP_SECT_B : `OP_SECT_A, r);
      for (int s = 0; s <= j; s++) begin
        stat(2'b01, 8'h58);
        rd_sec(28'(a + s), 1'b0, 1'b0, 1'b1);
      end
      stat(2'b00, 8'h50);
      chk_a(28'(a + j));
      a = rnd_a();
      st(a, 8'h03);
      lk(1'b1, 1'b0, 3'h7, j ? `OP_LONG_B : `OP_LONG_A, r);
      stat(2'b01, 8'h58);
      rd_sec(a, 1'b0, 1'b0, 1'b1);
      stat(2'b00, 8'h58);
      repeat (4) begin
        lk(1'b0, 1'b0, 3'h0, 8'h00, r);
        `CHK(r[15:8], 8'h00)
      end
      stat(2'b00, 8'h50);
    end
    lk(1'b1, 1'b0, 3'h2, 8'($random(seed)), r);
    lk(1'b1, 1'b0, 3'h7, `OP_READ_BUF, r);
    stat(2'b01, 8'h58);
    rd_sec(a, 1'b0, 1'b0, 1'b1);
    arm = 1'b0;
    lk(1'b1, 1'b0, 3'h7, `OP_DMA_A, r);
    ahb(1'b0, `HR_STAT, 32'h0, x);
    `CHK(x[3], 1'b1)
    `CHK(hresp, 1'b0)
    arm = 1'b1;
    for (int j = 0; j < 2; j++) begin
      a = rnd_a();
      st(a, 8'h01);
      lk(1'b1, 1'b0, 3'h7, j ? `OP_DMA_B : `OP_DMA_A, r);
      stat(2'b10, 8'h58);
      rd_sec(a, 1'b0, 1'b1, 1'b1);
      stat(2'b01, 8'h50);
      {bc, men} <= {8'(2 * j), 1'(1 - j)};
      lk(1'b1, 1'b0, 3'h7, `OP_MULT, r);
      stat(2'b01, 8'h51);
      lk(1'b0, 1'b0, 3'h1, 8'h00, r);
      `CHK(r[7:0], `ERR_ABORT)
    end
    {bc, men} <= {8'h02, 1'b1};
    for (int j = 0; j < 3; j++) begin
      a = rnd_a();
      {einj, ecorr, eaddr} <= {j != 0, j == 2, a + 28'h1};
      st(a, 8'h03);
      lk(1'b1, 1'b0, 3'h7, `OP_MULT, r);
      for (int s = 0; s < (j == 1 ? 2 : 3); s++) begin
        if (j == 0) stat(s == 1 ? 2'b00 : 2'b01, 8'h58);
        else if (s != 1) stat(2'b01, j == 1 ? 8'h59 : 8'h5C);
        rd_sec(28'(a + s), j != 0 && s == 1, 1'b0, 1'b1);
      end
      lk(1'b0, 1'b0, 3'h7, 8'h00, r);
      `CHK(r[3], 1'b0)
      chk_a(28'(j == 1 ? a + 1 : a + 2));
      lk(1'b0, 1'b0, 3'h1, 8'h00, r);
      if (j == 1) `CHK(r[7:0], `ERR_UNC)
    end
    end_of_test();
  end
endmodule
